// ---- hdl/apm_event_logic.sv ----
// apm_event_logic: power-management event registers, handshake bits and interrupt routing
// assumes one-cycle io strobes on clk; block bases and routing straps from config logic
//
// What this block does
// - legacy routing enable forwards power events to the management interrupt.
// - acpi routing enable forwards power events to the control interrupt.
// - management interrupt on its own pin, or serial irq pin in serial mode.
// - control interrupt on own pin, a selected irq line, or serial irq pin.
// - firmware release with global enable raises a control interrupt.
// - writing one to firmware release sets it and global status.
// - writing one to global status clears it and firmware release.
// - os release with firmware enable raises a management interrupt.
// - writing one to os release sets it and firmware status.
// - writing one to firmware status clears it and os release.
// - busmaster control with reload enable raises a control interrupt.
// - writing one to busmaster control sets it and busmaster status.
// - writing one to busmaster status clears it and busmaster control.
// - 24-bit free-running up counter at timer rate, read through three registers.
// - timer carry status sets on every change of counter bit 23.
// - timer carry enable lets carry status raise a control interrupt.
// - timer on bit gates the timer; it runs after power-up.
// - events set status regardless of enable; interrupts need enable.
// - status set by hardware or by writing one to its release or control bit; write one clears, zero keeps.
// - each enable sits at its status bit's position.
// - reserved enable and control bits read zero, writes ignored.
// - event group is a 16-bit status then a 16-bit enable.
// - timer carry enable is bit 0 at event block offset 2.
`timescale 1ns/100ps
module apm_event_logic (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire apm_pkg::apm_io_req_t  io_req,
	output apm_pkg::apm_io_rsp_t       io_rsp,
	input  wire logic [15:0]           pm1_base,
	input  wire logic [15:0]           gpe_base,
	input  wire logic                  legacy_route_enable,
	input  wire logic                  serial_irq_mode,
	input  wire logic [3:0]            sci_irq_select,
	output apm_pkg::apm_irq_out_t      irq_out
);
	import apm_pkg::*;

	apm_state_t          s_r;
	apm_state_t          s_nxt;
	logic [TIMER_W-1:0]  tmr_count;
	logic                tmr_carry;
	logic                pm1_hit;
	logic                gpe_hit;
	logic [7:0]          pm1_off;
	logic [7:0]          gpe_off;
	logic                pm_event;
	logic                smi_req;
	logic                sci_req;

	// address inside a block of given span
	function automatic logic blk_hit(input logic [15:0] addr, input logic [15:0] base,
		input logic [15:0] span);
		logic [15:0] d;
		d = addr - base;
		blk_hit = (addr >= base) && (d < span);
	endfunction

	function automatic logic [7:0] blk_off(input logic [15:0] addr, input logic [15:0] base);
		logic [15:0] d;
		d = addr - base;
		blk_off = d[7:0];
	endfunction

	apm_pm_timer #(
		.CLK_FREQ (CLK_HZ),
		.TICK_HZ  (TIMER_HZ)
	) u_timer (
		.clk    (clk),
		.rst    (rst),
		.enable (s_r.pm_timer_on),
		.count  (tmr_count),
		.carry  (tmr_carry)
	);

	always_comb begin
		pm1_hit = blk_hit(io_req.addr, pm1_base, PM1_SPAN);
		gpe_hit = blk_hit(io_req.addr, gpe_base, GPE_SPAN) && !pm1_hit;
		pm1_off = blk_off(io_req.addr, pm1_base);
		gpe_off = blk_off(io_req.addr, gpe_base);
	end

	// enabled event sources
	always_comb begin
		pm_event = (s_r.timer_carry_status && s_r.timer_carry_enable)
			|| (s_r.firmware_release && s_r.global_event_enable)
			|| (s_r.busmaster_control && s_r.busmaster_reload_enable);
		smi_req = (s_r.os_release && s_r.firmware_event_enable)
			|| (legacy_route_enable && pm_event);
		sci_req = s_r.acpi_route_enable && pm_event;
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp.hit   = 1'b0;
		s_nxt.rsp.rdata = REG_RST;

		// register writes
		if (io_req.wr && pm1_hit) begin
			case (pm1_off)
				PM1_STS_LO: begin
					if (io_req.wdata[STS_TMR_BIT]) begin
						s_nxt.timer_carry_status = 1'b0;
					end
					if (io_req.wdata[STS_BM_BIT]) begin
						s_nxt.busmaster_status  = 1'b0;
						s_nxt.busmaster_control = 1'b0;
					end
					if (io_req.wdata[STS_GBL_BIT]) begin
						s_nxt.global_event_status = 1'b0;
						s_nxt.firmware_release    = 1'b0;
					end
				end
				PM1_EN_LO: begin
					s_nxt.timer_carry_enable  = io_req.wdata[EN_TMR_BIT];
					s_nxt.global_event_enable = io_req.wdata[EN_GBL_BIT];
				end
				PM1_CNT_LO: begin
					s_nxt.acpi_route_enable       = io_req.wdata[CNT_ACPI_BIT];
					s_nxt.busmaster_reload_enable = io_req.wdata[CNT_BMRLD_BIT];
					if (io_req.wdata[CNT_OSRLS_BIT]) begin
						s_nxt.os_release            = 1'b1;
						s_nxt.firmware_event_status = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (io_req.wr && gpe_hit) begin
			case (gpe_off)
				GPE_STS_LO: begin
					if (io_req.wdata[GPE_FW_BIT]) begin
						s_nxt.firmware_event_status = 1'b0;
						s_nxt.os_release            = 1'b0;
					end
				end
				GPE_EN_LO: begin
					s_nxt.firmware_event_enable = io_req.wdata[GPE_FW_BIT];
				end
				GPE_CNT_LO: begin
					s_nxt.pm_timer_on = io_req.wdata[GPE_TMRON_BIT];
					if (io_req.wdata[GPE_FWRLS_BIT]) begin
						s_nxt.firmware_release    = 1'b1;
						s_nxt.global_event_status = 1'b1;
					end
					if (io_req.wdata[GPE_BMCTL_BIT]) begin
						s_nxt.busmaster_control = 1'b1;
						s_nxt.busmaster_status  = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// hardware set last so it wins over a clear
		if (tmr_carry) begin
			s_nxt.timer_carry_status = 1'b1;
		end

		// register reads, unlisted bits read zero
		if (io_req.rd && pm1_hit) begin
			s_nxt.rsp.hit = 1'b1;
			case (pm1_off)
				PM1_STS_LO: begin
					s_nxt.rsp.rdata[STS_TMR_BIT] = s_r.timer_carry_status;
					s_nxt.rsp.rdata[STS_BM_BIT]  = s_r.busmaster_status;
					s_nxt.rsp.rdata[STS_GBL_BIT] = s_r.global_event_status;
				end
				PM1_EN_LO: begin
					s_nxt.rsp.rdata[EN_TMR_BIT] = s_r.timer_carry_enable;
					s_nxt.rsp.rdata[EN_GBL_BIT] = s_r.global_event_enable;
				end
				PM1_CNT_LO: begin
					s_nxt.rsp.rdata[CNT_ACPI_BIT]  = s_r.acpi_route_enable;
					s_nxt.rsp.rdata[CNT_BMRLD_BIT] = s_r.busmaster_reload_enable;
					s_nxt.rsp.rdata[CNT_OSRLS_BIT] = s_r.os_release;
				end
				PM1_TMR_B0: s_nxt.rsp.rdata = tmr_count[7:0];
				PM1_TMR_B1: s_nxt.rsp.rdata = tmr_count[15:8];
				PM1_TMR_B2: s_nxt.rsp.rdata = tmr_count[23:16];
				default: s_nxt.rsp.rdata = REG_RST;
			endcase
		end
		if (io_req.rd && gpe_hit) begin
			s_nxt.rsp.hit = 1'b1;
			case (gpe_off)
				GPE_STS_LO: s_nxt.rsp.rdata[GPE_FW_BIT] = s_r.firmware_event_status;
				GPE_EN_LO:  s_nxt.rsp.rdata[GPE_FW_BIT] = s_r.firmware_event_enable;
				GPE_CNT_LO: begin
					s_nxt.rsp.rdata[GPE_TMRON_BIT] = s_r.pm_timer_on;
					s_nxt.rsp.rdata[GPE_FWRLS_BIT] = s_r.firmware_release;
					s_nxt.rsp.rdata[GPE_BMCTL_BIT] = s_r.busmaster_control;
				end
				default: s_nxt.rsp.rdata = REG_RST;
			endcase
		end

		// output steering, level follows the sources
		s_nxt.irq.smi_n              = PIN_IDLE_N;
		s_nxt.irq.sci_n              = PIN_IDLE_N;
		s_nxt.irq.irq_lines          = '0;
		s_nxt.irq.serial_irq_pin_smi = 1'b0;
		s_nxt.irq.serial_irq_pin_sci = 1'b0;
		if (serial_irq_mode) begin
			s_nxt.irq.serial_irq_pin_smi = smi_req;
			s_nxt.irq.serial_irq_pin_sci = sci_req;
		end else begin
			s_nxt.irq.smi_n = ~smi_req;
			if (sci_irq_select == SCI_SEL_PIN) begin
				s_nxt.irq.sci_n = ~sci_req;
			end else begin
				s_nxt.irq.irq_lines[sci_irq_select] = sci_req;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r             <= '0;
			s_r.pm_timer_on <= PM_TIMER_ON_RST;
			s_r.irq.smi_n   <= PIN_IDLE_N;
			s_r.irq.sci_n   <= PIN_IDLE_N;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign io_rsp  = s_r.rsp;
	assign irq_out = s_r.irq;
endmodule

// ---- hdl/apm_pm_timer.sv ----
// apm_pm_timer: 24-bit free-running counter ticking at the timer rate
// assumes clk at CLK_HZ; rate made by a fractional accumulator
`timescale 1ns/100ps
module apm_pm_timer #(
	parameter int unsigned CLK_FREQ = apm_pkg::CLK_HZ,
	parameter int unsigned TICK_HZ  = apm_pkg::TIMER_HZ
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        enable,
	output logic [apm_pkg::TIMER_W-1:0]      count,
	output logic                             carry
);
	import apm_pkg::*;

	localparam logic [TMR_ACC_W:0] INC = (TMR_ACC_W+1)'(TICK_HZ);
	localparam logic [TMR_ACC_W:0] DEN = (TMR_ACC_W+1)'(CLK_FREQ);

	generate
		if (TICK_HZ == 0 || TICK_HZ >= CLK_FREQ || CLK_FREQ >= (2 ** TMR_ACC_W)) begin : g_bad
			$error("apm_pm_timer: rate parameters out of range");
		end
	endgenerate

	apm_tmr_state_t s_r;
	apm_tmr_state_t s_nxt;
	logic [TMR_ACC_W:0] sum;

	always_comb begin
		s_nxt = s_r;
		s_nxt.carry = 1'b0;
		sum = {1'b0, s_r.acc} + INC;
		if (enable) begin
			if (sum >= DEN) begin
				s_nxt.acc   = TMR_ACC_W'(sum - DEN);
				s_nxt.count = s_r.count + 1'b1;
				// msb flips in either direction
				s_nxt.carry = s_nxt.count[TIMER_W-1] ^ s_r.count[TIMER_W-1];
			end else begin
				s_nxt.acc = sum[TMR_ACC_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.count;
	assign carry = s_r.carry;
endmodule

// ---- inc/apm_pkg.sv ----
// apm_pkg: constants, register map and carrier types of the power-management event logic
// assumes an 8-bit I/O port in the same clock domain as the logic
package apm_pkg;

	// clock and timer rates
	localparam int unsigned CLK_HZ     = 50000000;
	localparam int unsigned TIMER_HZ   = 3579545;
	localparam int unsigned TIMER_W    = 24;
	localparam int unsigned TMR_ACC_W  = 26;

	// event block, offsets from pm1_base
	localparam logic [7:0] PM1_STS_LO  = 8'h00;
	localparam logic [7:0] PM1_STS_HI  = 8'h01;
	localparam logic [7:0] PM1_EN_LO   = 8'h02;
	localparam logic [7:0] PM1_EN_HI   = 8'h03;
	localparam logic [7:0] PM1_CNT_LO  = 8'h04;
	localparam logic [7:0] PM1_CNT_HI  = 8'h05;
	localparam logic [7:0] PM1_TMR_B0  = 8'h08;
	localparam logic [7:0] PM1_TMR_B1  = 8'h09;
	localparam logic [7:0] PM1_TMR_B2  = 8'h0A;
	localparam logic [7:0] PM1_TMR_B3  = 8'h0B;
	localparam logic [15:0] PM1_SPAN   = 16'h0010;

	// general-purpose event block, offsets from gpe_base
	localparam logic [7:0] GPE_STS_LO  = 8'h00;
	localparam logic [7:0] GPE_STS_HI  = 8'h01;
	localparam logic [7:0] GPE_EN_LO   = 8'h02;
	localparam logic [7:0] GPE_EN_HI   = 8'h03;
	localparam logic [7:0] GPE_CNT_LO  = 8'h04;
	localparam logic [15:0] GPE_SPAN   = 16'h0008;

	// field positions, status and enable share positions
	localparam int unsigned STS_TMR_BIT   = 0;
	localparam int unsigned STS_BM_BIT    = 4;
	localparam int unsigned STS_GBL_BIT   = 5;
	localparam int unsigned EN_TMR_BIT    = 0;
	localparam int unsigned EN_GBL_BIT    = 5;
	localparam int unsigned CNT_ACPI_BIT  = 0;
	localparam int unsigned CNT_BMRLD_BIT = 1;
	localparam int unsigned CNT_OSRLS_BIT = 2;
	localparam int unsigned GPE_FW_BIT    = 0;
	localparam int unsigned GPE_TMRON_BIT = 0;
	localparam int unsigned GPE_FWRLS_BIT = 1;
	localparam int unsigned GPE_BMCTL_BIT = 2;

	// reset values
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic       BIT_RST      = 1'b0;
	localparam logic       PM_TIMER_ON_RST   = 1'b1;
	localparam logic       PIN_IDLE_N   = 1'b1;
	localparam logic [3:0] SCI_SEL_PIN  = 4'h0;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} apm_io_req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic       hit;
	} apm_io_rsp_t;

	typedef struct packed {
		logic        smi_n;
		logic        sci_n;
		logic [15:0] irq_lines;
		logic        serial_irq_pin_smi;
		logic        serial_irq_pin_sci;
	} apm_irq_out_t;

	typedef struct packed {
		logic [TMR_ACC_W-1:0] acc;
		logic [TIMER_W-1:0]   count;
		logic                 carry;
	} apm_tmr_state_t;

	typedef struct packed {
		logic         timer_carry_status;
		logic         busmaster_status;
		logic         global_event_status;
		logic         timer_carry_enable;
		logic         global_event_enable;
		logic         acpi_route_enable;
		logic         busmaster_reload_enable;
		logic         os_release;
		logic         firmware_event_status;
		logic         firmware_event_enable;
		logic         pm_timer_on;
		logic         firmware_release;
		logic         busmaster_control;
		apm_io_rsp_t  rsp;
		apm_irq_out_t irq;
	} apm_state_t;

endpackage

// ---- test/apm_event_logic_props.sv ----
// apm_event_logic_props: port-level checks of the event logic
// assumes binding to apm_event_logic, one clock, synchronous reset
`timescale 1ns/100ps
module apm_event_logic_props
	import apm_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire apm_pkg::apm_io_req_t  io_req,
	input wire apm_pkg::apm_io_rsp_t  io_rsp,
	input wire logic [15:0]           pm1_base,
	input wire logic [15:0]           gpe_base,
	input wire logic                  legacy_route_enable,
	input wire logic                  serial_irq_mode,
	input wire logic [3:0]            sci_irq_select,
	input wire apm_pkg::apm_irq_out_t irq_out
);
	logic [15:0] sel_mask;
	assign sel_mask = (sci_irq_select != 4'h0) ? (16'h0001 << sci_irq_select) : 16'h0000;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rd(logic [15:0] a);
		io_req.rd && io_req.addr == a;
	endsequence
	a_rd_answer: assert property (io_req.rd && (io_req.addr - pm1_base) < 16'h0010 |=> io_rsp.hit)
		else $error("mapped read not answered");
	a_hit_cause: assert property (io_rsp.hit |-> $past(io_req.rd))
		else $error("hit without read");
	a_miss_zero: assert property (!io_rsp.hit |-> io_rsp.rdata == 8'h00)
		else $error("data without hit");
	a_status_hi_zero: assert property (s_rd(pm1_base + 16'h0001) |=> io_rsp.rdata == 8'h00)
		else $error("upper status byte not zero");
	a_status_resv: assert property (s_rd(pm1_base) |=> (io_rsp.rdata & 8'hCE) == 8'h00)
		else $error("reserved status bits set");
	a_enable_resv: assert property (s_rd(pm1_base + 16'h0002) |=> (io_rsp.rdata & 8'hDE) == 8'h00)
		else $error("reserved enable bits set");
	a_serial_idle: assert property (serial_irq_mode && $past(serial_irq_mode)
		|-> irq_out.smi_n && irq_out.sci_n && irq_out.irq_lines == 16'h0000)
		else $error("pins active in serial mode");
	a_line_only: assert property ($stable(sci_irq_select) |-> (irq_out.irq_lines & ~sel_mask) == 16'h0000)
		else $error("unselected irq line high");
	a_pin_unused: assert property (!serial_irq_mode && !$past(serial_irq_mode) && sci_irq_select != 4'h0
		&& $stable(sci_irq_select) |-> irq_out.sci_n)
		else $error("control pin active with line selected");
	a_serial_quiet: assert property (!serial_irq_mode && !$past(serial_irq_mode)
		|-> !irq_out.serial_irq_pin_smi && !irq_out.serial_irq_pin_sci)
		else $error("serial request in pin mode");
	a_gpe_answer: assert property (io_req.rd && (io_req.addr - gpe_base) < 16'h0008 |=> io_rsp.hit)
		else $error("event block read not answered");
	a_legacy_follow: assert property ($past(legacy_route_enable) && !$past(serial_irq_mode)
		&& irq_out.irq_lines != 16'h0000 |-> !irq_out.smi_n)
		else $error("routed event missing on management pin");
	a_legacy_serial: assert property ($past(legacy_route_enable) && irq_out.serial_irq_pin_sci
		|-> irq_out.serial_irq_pin_smi)
		else $error("routed event missing on serial management request");
endmodule
bind apm_event_logic apm_event_logic_props u_props (.clk(clk), .rst(rst), .io_req(io_req),
	.io_rsp(io_rsp), .pm1_base(pm1_base), .gpe_base(gpe_base),
	.legacy_route_enable(legacy_route_enable), .serial_irq_mode(serial_irq_mode),
	.sci_irq_select(sci_irq_select), .irq_out(irq_out));

// ---- test/apm_event_logic_test.sv ----
// apm_event_logic_test: register model compared with the event logic
// assumes apm_host drives the port, bases fixed for the run
`timescale 1ns/100ps
module apm_event_logic_test;
	import apm_pkg::*;
	localparam logic [15:0] PM1 = 16'h0400;
	localparam logic [15:0] GPE = 16'h0420;
	logic         clk;
	logic         rst;
	apm_io_req_t  io_req;
	apm_io_rsp_t  io_rsp;
	apm_irq_out_t irq_out;
	logic         leg;
	logic         ser;
	logic [3:0]   sel;
	logic [7:0]   d;
	logic         h;
	logic [23:0]  t0;
	logic [23:0]  t1;
	int           fails;
	int           n_tests;
	int           st, en, ct, gs, ge, gc, k;
	apm_event_logic uut (.clk(clk), .rst(rst), .io_req(io_req), .io_rsp(io_rsp), .pm1_base(PM1),
		.gpe_base(GPE), .legacy_route_enable(leg), .serial_irq_mode(ser),
		.sci_irq_select(sel), .irq_out(irq_out));
	apm_host host (.clk(clk), .io_req(io_req), .io_rsp(io_rsp));
	function automatic logic [7:0] mrd(input int g, input int o);
		int v;
		v = (g == 0) ? ((o == 0) ? st : (o == 2) ? en : (o == 4) ? ct : 0)
			: ((o == 0) ? gs : (o == 2) ? ge : (o == 4) ? gc : 0);
		return v[7:0];
	endfunction
	function automatic apm_irq_out_t mirq();
		apm_irq_out_t e;
		int ev, smi, sci;
		ev = (st & en & 1) | ((gc >> 1) & 1 & (en >> 5)) | ((gc >> 2) & (ct >> 1) & 1);
		smi = ((ct >> 2) & ge & 1) | (leg & ev);
		sci = ct & 1 & ev;
		e = '{smi_n: 1'b1, sci_n: 1'b1, irq_lines: 16'h0000, serial_irq_pin_smi: 1'b0,
			serial_irq_pin_sci: 1'b0};
		if (ser) begin
			e.serial_irq_pin_smi = smi[0];
			e.serial_irq_pin_sci = sci[0];
		end else begin
			e.smi_n = !smi[0];
			if (sel == 4'h0) e.sci_n = !sci[0];
			else e.irq_lines[sel] = sci[0];
		end
		return e;
	endfunction
	task automatic chk_rd(input logic [7:0] gd, input logic gh, input logic [7:0] ed, input logic eh);
		n_tests++;
		if (gd !== ed || gh !== eh) begin
			fails++;
			$display("ERROR %0t read got %h/%b exp %h/%b", $time, gd, gh, ed, eh);
		end
	endtask
	task automatic chk_irq(input apm_irq_out_t g);
		n_tests++;
		if (g !== mirq()) begin
			fails++;
			$display("ERROR %0t irq got %h exp %h", $time, g, mirq());
		end
	endtask
	task automatic chk_tmr(input logic [23:0] a, input logic [23:0] b, input int lo, input int hi);
		n_tests++;
		if ($isunknown({a, b}) || int'(b - a) < lo || int'(b - a) > hi) begin
			fails++;
			$display("ERROR %0t timer %h then %h", $time, a, b);
		end
	endtask
	task automatic w(input int g, input int o, input logic [7:0] v);
		host.io_wr((g != 0 ? GPE : PM1) + 16'(o), v);
		if (g == 0 && o == 0) begin
			st = st & ~int'(v & 8'h31);
			if (v[4]) gc = gc & ~4;
			if (v[5]) gc = gc & ~2;
		end
		if (g == 0 && o == 2) en = v & 8'h21;
		if (g == 0 && o == 4) ct = (ct & 4) | (v & 7);
		if (g == 0 && o == 4 && v[2]) gs = 1;
		if (g == 1 && o == 0 && v[0]) begin
			gs = 0;
			ct = ct & 3;
		end
		if (g == 1 && o == 2) ge = v & 1;
		if (g == 1 && o == 4) begin
			gc = (gc & 6) | (v & 7);
			if (v[1]) st = st | 32;
			if (v[2]) st = st | 16;
		end
	endtask
	task automatic r(input int g, input int o);
		host.io_rd((g != 0 ? GPE : PM1) + 16'(o), d, h);
		chk_rd(d, h, mrd(g, o), 1'b1);
	endtask
	task automatic pins();
		repeat (3) @(negedge clk);
		chk_irq(irq_out);
	endtask
	task automatic rt(output logic [23:0] v);
		for (int i = 0; i < 3; i++) begin
			host.io_rd(PM1 + 16'h0008 + 16'(i), d, h);
			v[8*i+:8] = d;
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		fails++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		leg = 1'b0;
		ser = 1'b0;
		sel = 4'h0;
		{st, en, ct, gs, ge, gc, fails, n_tests} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd1, 64'd0};
		k = $urandom(69988);
		repeat (5) @(negedge clk);
		rst = 1'b0;
		for (k = 0; k < 6; k++) r(k / 3, 2 * (k % 3));
		for (k = 1; k < 13; k += 2) r(0, k);
		host.io_rd(16'h0430, d, h);
		chk_rd(d, h, 8'h00, 1'b0);
		repeat (4) begin
			w(0, 2, 8'($urandom));
			r(0, 2);
		end
		w(0, 2, 8'h21);
		w(0, 4, 8'h01);
		w(1, 4, 8'h03);
		r(0, 0);
		pins();
		w(0, 0, 8'h00);
		r(1, 4);
		w(0, 0, 8'h20);
		r(1, 4);
		pins();
		w(1, 2, 8'h01);
		w(0, 4, 8'h05);
		r(1, 0);
		pins();
		w(1, 0, 8'h01);
		r(0, 4);
		pins();
		w(0, 4, 8'h03);
		w(1, 4, 8'h05);
		r(0, 0);
		for (k = 0; k < 32; k++) begin
			leg = k[0];
			ser = k[4];
			sel = k[3:0];
			pins();
		end
		w(0, 0, 8'h10);
		r(1, 4);
		pins();
		rt(t0);
		repeat (140) @(negedge clk);
		rt(t1);
		chk_tmr(t0, t1, 9, 12);
		w(1, 4, 8'h00);
		rt(t0);
		repeat (140) @(negedge clk);
		rt(t1);
		chk_tmr(t0, t1, 0, 0);
		r(1, 4);
		report_and_stop();
	end
endmodule

// ---- test/apm_host.sv ----
// apm_host: host side of the I/O port, byte reads and writes
// assumes strobes taken on the rising edge, answer one cycle later
`timescale 1ns/100ps
module apm_host
	import apm_pkg::*;
(
	input  wire logic                 clk,
	output apm_pkg::apm_io_req_t      io_req,
	input  wire apm_pkg::apm_io_rsp_t io_rsp
);
	initial io_req = '{addr: 16'hFFFF, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
	task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clk);
		io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
		@(negedge clk);
		io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
	endtask
	task automatic io_rd(input logic [15:0] a, output logic [7:0] v, output logic h);
		@(negedge clk);
		io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~io_req.wdata};
		@(negedge clk);
		v = io_rsp.rdata;
		h = io_rsp.hit;
		io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~io_req.wdata};
	endtask
endmodule
